// File: core/sas_pkg.sv
package sas_pkg;
   // register map of the converter
   localparam logic [7:0] ADDR_CONTROL = 8'hF8;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'hE2;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] RESULT_HIGH_RESET = 8'h00;

   // field positions in converter_control_zero
   localparam int POS_RESULT_BIT1 = 7;
   localparam int POS_RESULT_BIT0 = 6;
   localparam int POS_EXT_START_ENABLE = 5;
   localparam int POS_DONE_FLAG = 4;
   localparam int POS_START_STATUS = 3;
   localparam int POS_CHANNEL_HI = 2;
   localparam int POS_CHANNEL_LO = 0;

   // sequence lengths in machine cycles, bit count and steps per bit trial
   localparam int INIT_MC = 2;
   localparam int SAMPLE_MC = 8;
   localparam int TOTAL_MC = 35;
   localparam int BIT_COUNT = 10;
   localparam int STEPS_PER_BIT = 4;

   // core clocks per machine cycle, default value, and core clock period
   localparam int MC_CLKS_DEF = 8;
   localparam int CLK_PERIOD_NS = 4;

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_INIT,
      ST_SAMPLE,
      ST_CONVERT
   } sas_state_type;
endpackage

// File: core/sas_sync2.sv
`timescale 1ns/1ps
module sas_sync2 (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // asynchronous level and its synchronised copy
   input wire logic async_in,
   output logic sync_out
);
   logic meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         meta_ff <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule

// File: core/sas_mcycle.sv
`timescale 1ns/1ps
module sas_mcycle #(
   parameter int MC_CLKS = sas_pkg::MC_CLKS_DEF
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // one-cycle pulse in the last clock of each machine cycle
   output logic tick_out
);
   localparam int CW = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;
   localparam logic [CW-1:0] LAST = CW'(MC_CLKS - 1);
   logic [CW-1:0] cnt_ff;

   // free running divider; the tick is registered so it lines up with cnt wrap
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         cnt_ff <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
         tick_out <= (MC_CLKS == 1) ? 1'b1 : (cnt_ff == LAST - 1'b1);
      end
   end
endmodule

// File: core/sas_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - external enable clear: only software start bit begins a conversion
// - external enable set: software start or pin rising edge begins conversion
// - pin edge seen at machine cycle end; conversion begins next cycle
// - software start begins at the machine cycle after the write
// - start bit is a command flop plus a separate read status flop
// - two init cycles; busy reads one after first; sampling after second
// - selected channel is sampled for eight machine cycles
// - approximation starts at top bit; keep bit if input above dac
// - every bit trial spans four conversion steps
// - completion sets done, result high byte, low bits in control 7:6
// - done set and busy cleared 35 machine cycles after start
// - control bits 2:0 select one of eight multiplexer channels
// - channel writes take effect only while done and busy are zero
// - start requests during a conversion are ignored
// - idle or power-down entry aborts; a finished result is kept
// - pin start still accepted in idle when external start enabled
// - done flag raises interrupt request; software cannot set done
// - software clearing the start bit aborts a running conversion
// - no new start while busy or done is one
// - clearing done with start in one write may start a conversion
// - with the converter disabled its register bits are inert
module sas_sequencer #(
   parameter int MC_CLKS = sas_pkg::MC_CLKS_DEF,
   parameter int RES_W = sas_pkg::BIT_COUNT
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // special function register port
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   // processor state and converter enable
   input wire logic adc_enable_in,
   input wire logic idle_mode_in,
   input wire logic powerdown_in,
   input wire logic int_enable_in,
   // external start pin
   input wire logic ext_start_pin_in,
   // analog front end
   input wire logic comparator_in,
   output logic [RES_W-1:0] dac_code_out,
   output logic [2:0] mux_sel_out,
   output logic sample_out,
   // interrupt request
   output logic irq_out
);
   localparam int BIT_MC = sas_pkg::TOTAL_MC - sas_pkg::INIT_MC - sas_pkg::SAMPLE_MC;
   localparam int STEP_CLKS = (MC_CLKS * BIT_MC) / (RES_W * sas_pkg::STEPS_PER_BIT);
   localparam int TRIAL_CLKS = STEP_CLKS * sas_pkg::STEPS_PER_BIT;
   localparam int INIT_CLKS = sas_pkg::INIT_MC * MC_CLKS;
   localparam int SAMPLE_CLKS = sas_pkg::SAMPLE_MC * MC_CLKS;
   localparam int CNT_W = $clog2(SAMPLE_CLKS + INIT_CLKS + TRIAL_CLKS + 1);
   localparam logic [CNT_W-1:0] BUSY_AT = CNT_W'(MC_CLKS - 1);
   localparam logic [CNT_W-1:0] INIT_END = CNT_W'(INIT_CLKS - 1);
   localparam logic [CNT_W-1:0] SAMPLE_END = CNT_W'(SAMPLE_CLKS - 1);
   localparam logic [CNT_W-1:0] TRIAL_END = CNT_W'(TRIAL_CLKS - 1);
   localparam logic [3:0] TOP_BIT = 4'(RES_W - 1);

   sas_pkg::sas_state_type state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [3:0] bit_ff;
   logic [RES_W-1:0] sar_ff;
   logic [RES_W-1:0] result_ff;
   logic cmd_ff;
   logic status_ff;
   logic done_ff;
   logic ext_en_ff;
   logic [2:0] chan_ff;
   logic pin_sync;
   logic pin_prev_ff;
   logic low_power_prev_ff;
   logic mc_tick;
   logic ctrl_wr;
   logic ext_edge;
   logic start_req;
   logic start_go;
   logic abort;
   logic trial_end;
   logic done_set;

   sas_sync2 u_pin_sync (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .async_in(ext_start_pin_in),
      .sync_out(pin_sync)
   );

   // machine cycle boundaries
   sas_mcycle #(
      .MC_CLKS(MC_CLKS)
   ) u_mcycle (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .tick_out(mc_tick)
   );

   assign ctrl_wr = adc_enable_in && sfr_wr_in && (sfr_addr_in == sas_pkg::ADDR_CONTROL);

   assign ext_edge = mc_tick && pin_sync && !pin_prev_ff;

   assign start_req = cmd_ff || (ext_en_ff && ext_edge && !powerdown_in);

   assign start_go = adc_enable_in && mc_tick && start_req && (state_ff == sas_pkg::ST_IDLE)
      && !status_ff && !done_ff && !abort;

   assign abort = (state_ff != sas_pkg::ST_IDLE)
      && ((ctrl_wr && !sfr_wdata_in[sas_pkg::POS_START_STATUS])
      || ((idle_mode_in || powerdown_in) && !low_power_prev_ff)
      || !adc_enable_in);

   assign trial_end = (state_ff == sas_pkg::ST_CONVERT) && (cnt_ff == TRIAL_END);
   assign done_set = trial_end && (bit_ff == 4'h0) && !abort;

   // pin level at the previous machine cycle end, and low-power entry detect
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         pin_prev_ff <= 1'b0;
         low_power_prev_ff <= 1'b0;
      end
      else
      begin
         if (mc_tick)
         begin
            pin_prev_ff <= pin_sync;
         end
         low_power_prev_ff <= idle_mode_in || powerdown_in;
      end
   end

   // consumed at the next machine cycle end
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         cmd_ff <= 1'b0;
      end
      else if (ctrl_wr && sfr_wdata_in[sas_pkg::POS_START_STATUS])
      begin
         cmd_ff <= 1'b1;
      end
      else if (mc_tick || !adc_enable_in)
      begin
         cmd_ff <= 1'b0; // a refused request is dropped, not queued
      end
   end

   // sequencer: init, sample window, bit trials
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         state_ff <= sas_pkg::ST_IDLE;
         cnt_ff <= '0;
         bit_ff <= 4'h0;
         sar_ff <= '0;
      end
      else if (abort)
      begin
         state_ff <= sas_pkg::ST_IDLE;
         cnt_ff <= '0;
      end
      else
      begin
         case (state_ff)
            sas_pkg::ST_IDLE:
            begin
               if (start_go)
               begin
                  state_ff <= sas_pkg::ST_INIT;
                  cnt_ff <= '0;
               end
            end
            sas_pkg::ST_INIT:
            begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == INIT_END)
               begin
                  state_ff <= sas_pkg::ST_SAMPLE;
                  cnt_ff <= '0;
               end
            end
            sas_pkg::ST_SAMPLE:
            begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == SAMPLE_END)
               begin
                  state_ff <= sas_pkg::ST_CONVERT;
                  cnt_ff <= '0;
                  bit_ff <= TOP_BIT;
                  sar_ff <= {1'b1, {(RES_W - 1){1'b0}}};
               end
            end
            sas_pkg::ST_CONVERT:
            begin
               cnt_ff <= cnt_ff + 1'b1;
               if (trial_end)
               begin
                  cnt_ff <= '0;
                  sar_ff[bit_ff] <= comparator_in;
                  if (bit_ff == 4'h0)
                  begin
                     state_ff <= sas_pkg::ST_IDLE;
                  end
                  else
                  begin
                     sar_ff[bit_ff - 4'h1] <= 1'b1;
                     bit_ff <= bit_ff - 4'h1;
                  end
               end
            end
            default:
            begin
               state_ff <= sas_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // cleared with done at 35 cycles
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         status_ff <= 1'b0;
      end
      else if (done_set || abort)
      begin
         status_ff <= 1'b0;
      end
      else if (state_ff == sas_pkg::ST_INIT && cnt_ff == BUSY_AT)
      begin
         status_ff <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         done_ff <= 1'b0;
      end
      else if (done_set)
      begin
         done_ff <= 1'b1; // set beats a clear in the same cycle
      end
      else if (ctrl_wr && !sfr_wdata_in[sas_pkg::POS_DONE_FLAG])
      begin
         done_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         result_ff <= '0;
      end
      else if (done_set)
      begin
         result_ff <= {sar_ff[RES_W-1:1], comparator_in};
      end
   end

   // control fields written by software
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         ext_en_ff <= sas_pkg::CONTROL_RESET[sas_pkg::POS_EXT_START_ENABLE];
         chan_ff <= sas_pkg::CONTROL_RESET[sas_pkg::POS_CHANNEL_HI:sas_pkg::POS_CHANNEL_LO];
      end
      else if (ctrl_wr)
      begin
         ext_en_ff <= sfr_wdata_in[sas_pkg::POS_EXT_START_ENABLE];
         if (!done_ff && !status_ff && state_ff == sas_pkg::ST_IDLE)
         begin
            chan_ff <= sfr_wdata_in[sas_pkg::POS_CHANNEL_HI:sas_pkg::POS_CHANNEL_LO];
         end
      end
   end

   // read data registered one clock after the read strobe
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         sfr_rdata_out <= 8'h00;
      end
      else if (sfr_rd_in && adc_enable_in && sfr_addr_in == sas_pkg::ADDR_CONTROL)
      begin
         sfr_rdata_out <= {result_ff[1:0], ext_en_ff, done_ff, status_ff, chan_ff};
      end
      else if (sfr_rd_in && adc_enable_in && sfr_addr_in == sas_pkg::ADDR_RESULT_HIGH)
      begin
         sfr_rdata_out <= result_ff[RES_W-1:2];
      end
      else
      begin
         sfr_rdata_out <= 8'h00;
      end
   end

   // analog side and interrupt request
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         dac_code_out <= '0;
         mux_sel_out <= 3'h0;
         sample_out <= 1'b0;
         irq_out <= 1'b0;
      end
      else
      begin
         dac_code_out <= sar_ff;
         mux_sel_out <= chan_ff;
         sample_out <= (state_ff == sas_pkg::ST_SAMPLE) && !abort;
         irq_out <= adc_enable_in && int_enable_in && (done_ff || done_set);
      end
   end
endmodule

// File: bench/sas_front_model.sv
`timescale 1ns/1ps
module sas_front_model (
   // clock
   input wire logic core_clk_in,
   // converter side
   input wire logic [9:0] dac_code_in,
   input wire logic [2:0] mux_sel_in,
   input wire logic sample_in,
   // comparator decision
   output logic comparator_out
);
   logic [9:0] held_ff;
   // track and hold; each channel sits at its own level so a wrong channel shows in the result
   always_ff @(posedge core_clk_in)
   begin
      if (sample_in)
      begin
         held_ff <= {mux_sel_in, 7'h2B};
      end
   end
   // high while the held level is above the dac tap
   assign comparator_out = held_ff > dac_code_in;
endmodule

// File: bench/sas_sequencer_asserts.sv
`timescale 1ns/1ps
module sas_sequencer_asserts #(
   parameter int MC_CLKS = 8
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // watched ports
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic adc_enable_in,
   input wire logic int_enable_in,
   input wire logic [9:0] dac_code_out,
   input wire logic [2:0] mux_sel_out,
   input wire logic sample_out,
   input wire logic irq_out,
   input wire logic [7:0] sfr_wdata_in
);
   localparam int GAP_LO = 25 * MC_CLKS - 3;
   localparam int GAP_HI = 25 * MC_CLKS + 3;
   localparam int TRIAL = MC_CLKS * 5 / 2;
   logic [15:0] run_ff;
   logic [15:0] gap_ff;
   logic [15:0] chg_ff;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (srst_in);
   // length of the open sample window
   always_ff @(posedge core_clk_in)
   begin
      run_ff <= (srst_in || !sample_out) ? 16'h0000 : run_ff + 16'h0001;
   end
   // time since the window closed, saturating so idle spans never wrap
   always_ff @(posedge core_clk_in)
   begin
      gap_ff <= (srst_in || sample_out) ? 16'h0000 : gap_ff + {15'h0000, gap_ff != 16'hFFFF};
   end
   // clocks since the dac code last moved
   always_ff @(posedge core_clk_in)
   begin
      chg_ff <= $changed(dac_code_out) ? 16'h0001 : chg_ff + {15'h0000, chg_ff != 16'hFFFF};
   end
   a_off_read: assert property ($past(sfr_rd_in) && !$past(adc_enable_in) |-> sfr_rdata_out == 8'h00)
      else $error("read of disabled converter not zero");
   a_off_quiet: assert property (!adc_enable_in |-> ##2 !sample_out && !irq_out)
      else $error("disabled converter still active");
   a_irq_cause: assert property (irq_out |-> $past(int_enable_in) && $past(adc_enable_in))
      else $error("irq without enable");
   a_irq_clear: assert property (sfr_wr_in && sfr_addr_in == 8'hF8 && !sfr_wdata_in[4]
      && adc_enable_in |-> ##3 !irq_out)
      else $error("irq stays after done cleared");
   a_irq_time: assert property ($rose(irq_out) && $past(int_enable_in, 2)
      |-> gap_ff >= GAP_LO && gap_ff <= GAP_HI)
      else $error("done not 25 machine cycles after sampling");
   a_sample_len: assert property ($fell(sample_out) |-> run_ff == 8 * MC_CLKS)
      else $error("sample window length wrong");
   a_mux_hold: assert property (sample_out |-> $stable(mux_sel_out))
      else $error("channel moved while sampling");
   a_sar_top: assert property ($fell(sample_out) |-> ##[0:3] dac_code_out == 10'h200)
      else $error("approximation not started at top bit");
   a_trial_len: assert property ($changed(dac_code_out) && dac_code_out != 10'h200
      && dac_code_out != 10'h000 && $past(dac_code_out) != 10'h000 |-> chg_ff == TRIAL)
      else $error("bit trial length wrong");
endmodule
bind sas_sequencer sas_sequencer_asserts #(.MC_CLKS(MC_CLKS)) u_chk (.core_clk_in(core_clk_in),
   .srst_in(srst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
   .sfr_rdata_out(sfr_rdata_out), .adc_enable_in(adc_enable_in), .int_enable_in(int_enable_in),
   .dac_code_out(dac_code_out), .mux_sel_out(mux_sel_out), .sample_out(sample_out),
   .irq_out(irq_out), .sfr_wdata_in(sfr_wdata_in));

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam int MC = 8;
   typedef struct packed {logic [2:0] ch; logic use_pin; logic [9:0] res;} sas_row_type;
   sas_row_type rows [8] = '{'{3'h0, 1'b0, 10'h02A}, '{3'h1, 1'b1, 10'h0AA},
      '{3'h2, 1'b0, 10'h12A}, '{3'h3, 1'b1, 10'h1AA}, '{3'h4, 1'b0, 10'h22A},
      '{3'h5, 1'b1, 10'h2AA}, '{3'h6, 1'b0, 10'h32A}, '{3'h7, 1'b1, 10'h3AA}};
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic en = 1'b1;
   logic idle = 1'b0;
   logic pd = 1'b0;
   logic ie = 1'b1;
   logic pin = 1'b0;
   logic [7:0] rdata;
   logic [9:0] dac;
   logic [2:0] mux;
   logic smp;
   logic irq;
   logic comp;
   logic [7:0] got;
   logic [7:0] ctrl;
   int err_count = 0;
   int n_compared = 0;
   int cyc;
   sas_sequencer #(.MC_CLKS(MC)) uut (.core_clk_in(core_clk_in), .srst_in(srst_in),
      .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
      .sfr_rdata_out(rdata), .adc_enable_in(en), .idle_mode_in(idle), .powerdown_in(pd),
      .int_enable_in(ie), .ext_start_pin_in(pin), .comparator_in(comp), .dac_code_out(dac),
      .mux_sel_out(mux), .sample_out(smp), .irq_out(irq));
   sas_front_model u_front (.core_clk_in(core_clk_in), .dac_code_in(dac), .mux_sel_in(mux),
      .sample_in(smp), .comparator_out(comp));
   // free-running 250 MHz clock
   initial
   begin
      forever #2 core_clk_in = ~core_clk_in;
   end
   task automatic final_report();
      if (err_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // strobes last one clock, launched on the falling edge
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_in);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge core_clk_in);
      wr = 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk_in);
      addr = a;
      rd = 1'b1;
      @(negedge core_clk_in);
      rd = 1'b0;
      d = rdata;
   endtask
   // low two machine cycles, then high three, so two ticks see the low level and three the high
   task automatic pin_pulse();
      pin = 1'b0;
      repeat (2 * MC) @(negedge core_clk_in);
      pin = 1'b1;
      repeat (3 * MC) @(negedge core_clk_in);
      pin = 1'b0;
   endtask
   // poll the control register; the bound stops a lost completion from hanging
   task automatic wait_done(output int n);
      n = 0;
      got = 8'h00;
      while (got[4] !== 1'b1 && n < 400)
      begin
         sfr_rd(8'hF8, got);
         n++;
      end
      // a completion that never shows is a failure in itself
      if (n >= 400)
         err_count++;
   endtask
   // give up if the sequence stalls somewhere
   initial
   begin
      #100000;
      err_count++;
      final_report();
   end
   initial
   begin
      repeat (6) @(negedge core_clk_in);
      srst_in = 1'b0;
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h00);
      sfr_rd(8'hE2, got);
      cmp8(got, 8'h00);
      sfr_rd(8'h10, got);
      cmp8(got, 8'h00);
      // every channel, odd ones started from the pin
      for (int i = 0; i < 8; i++)
      begin
         ctrl = {2'b00, rows[i].use_pin, 2'b00, rows[i].ch};
         sfr_wr(8'hF8, ctrl);
         if (rows[i].use_pin)
            pin_pulse();
         else
            sfr_wr(8'hF8, ctrl | 8'h08);
         wait_done(cyc);
         if (!rows[i].use_pin)
            cmp8({7'h00, cyc * 2 >= 35 * MC - 4 && cyc * 2 <= 36 * MC + 4}, 8'h01);
         cmp8(got, {rows[i].res[1:0], rows[i].use_pin, 2'b10, rows[i].ch});
         sfr_rd(8'hE2, got);
         cmp8(got, rows[i].res[9:2]);
         cmp8({5'h00, mux}, {5'h00, rows[i].ch});
         cmp8({7'h00, irq}, 8'h01);
         sfr_wr(8'hF8, ctrl);
      end
      // pin with external start off, then an attempt to set done by software
      sfr_wr(8'hF8, 8'h02);
      pin_pulse();
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h82);
      sfr_wr(8'hF8, 8'h12);
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h82);
      // converter off: writes lost, reads zero
      en = 1'b0;
      sfr_wr(8'hF8, 8'h0A);
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h00);
      en = 1'b1;
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h82);
      // channel change and restart attempt in mid conversion
      sfr_wr(8'hF8, 8'h0B);
      repeat (100) @(negedge core_clk_in);
      sfr_wr(8'hF8, 8'h0D);
      cmp8({5'h00, mux}, 8'h03);
      wait_done(cyc);
      cmp8(got, 8'h93);
      sfr_rd(8'hE2, got);
      cmp8(got, rows[3].res[9:2]);
      // clear done and start in one write, then abort it once the bit trials run
      // so the sample window is never cut short and the approximation has left its top code
      sfr_wr(8'hF8, 8'h0B);
      repeat (120) @(negedge core_clk_in);
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h8B);
      sfr_wr(8'hF8, 8'h03);
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h83);
      sfr_rd(8'hE2, got);
      cmp8(got, rows[3].res[9:2]);
      // idle entry aborts, a pin start in idle still completes and survives idle
      sfr_wr(8'hF8, 8'h2B);
      repeat (150) @(negedge core_clk_in);
      idle = 1'b1;
      sfr_rd(8'hF8, got);
      cmp8(got, 8'hA3);
      pin_pulse();
      wait_done(cyc);
      cmp8(got, 8'hB3);
      idle = 1'b0;
      @(negedge core_clk_in);
      idle = 1'b1;
      sfr_rd(8'hF8, got);
      cmp8(got, 8'hB3);
      idle = 1'b0;
      ie = 1'b0;
      repeat (3) @(negedge core_clk_in);
      cmp8({7'h00, irq}, 8'h00);
      ie = 1'b1;
      // power-down entry in mid conversion aborts it and keeps the old result
      sfr_wr(8'hF8, 8'h0B);
      repeat (150) @(negedge core_clk_in);
      pd = 1'b1;
      sfr_rd(8'hF8, got);
      cmp8(got, 8'h83);
      sfr_rd(8'hE2, got);
      cmp8(got, rows[3].res[9:2]);
      pd = 1'b0;
      final_report();
   end
endmodule
